//--- design/sac_ctrl.sv
// conversion control for a 10-bit successive approximation converter
// assumes control bits, read strobes and trigger sources on clk_i; comparator is asynchronous
`timescale 1ns/10ps
module sac_ctrl #(
	parameter int unsigned PRESCALE = 4,
	parameter logic [sac_pkg::TSEL_W-1:0] FREE_RUN_SEL = 3'h0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic start_wr_i,
	input wire logic auto_trig_en_i,
	input wire logic [sac_pkg::TSEL_W-1:0] trig_sel_i,
	input wire logic [sac_pkg::NUM_SRC-1:0] trig_src_i,
	input wire logic left_align_i,
	input wire logic [sac_pkg::REF_W-1:0] ref_sel_i,
	input wire logic [sac_pkg::CHAN_W-1:0] chan_sel_i,
	input wire logic low_rd_i,
	input wire logic high_rd_i,
	input wire logic flag_clr_i,
	input wire logic int_en_i,
	input wire logic comparator_i,
	output logic start_bit_o,
	output logic flag_o,
	output logic irq_o,
	output sac_pkg::sac_result_t result_o,
	output sac_pkg::sac_route_t route_o,
	output logic analog_en_o,
	output logic sample_o,
	output logic [sac_pkg::RES_W-1:0] trial_code_o
);
	import sac_pkg::*;

	localparam int unsigned PS_W = $clog2(PRESCALE);
	localparam logic [PS_W-1:0] PS_LAST = PS_W'(PRESCALE - 1);
	localparam logic [PS_W-1:0] PS_ZERO = '0;

	// the comparator must settle through its synchroniser between decisions
	if (PRESCALE < 4) begin : g_prescale_min
		$error("PRESCALE must be at least 4");
	end
	// every select code must name a source, so no code indexes past the vector
	if (NUM_SRC < (1 << TSEL_W)) begin : g_src_count
		$error("NUM_SRC must cover every trigger select code");
	end

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_CONV
	} sac_state_t;

	function automatic logic is_single(input logic [CHAN_W-1:0] code);
		is_single = (code < DIFF_FIRST) || (code >= DIFF_END);
	endfunction

	sac_state_t state_q;
	logic [PS_W-1:0] ps_q;
	logic tick;
	logic cmp_meta_q;
	logic cmp_q;
	logic trig_prev_q;
	logic trig_now;
	logic trig_edge;
	logic free_run;
	logic pending_q;
	logic first_q;
	logic [CNT_W-1:0] len_q;
	logic [CNT_W-1:0] cnt_q;
	logic [RES_W-1:0] trial_q;
	logic [RES_W-1:0] bit_q;
	logic [RES_W-1:0] data_q;
	logic lock_q;
	logic flag_q;
	logic done;
	logic hw_start;
	logic sample_q;
	logic irq_q;
	logic en_q;
	sac_route_t route_q;
	sac_result_t result_q;

	// pick the selected source, never any other
	assign trig_now = trig_src_i[trig_sel_i];
	assign free_run = auto_trig_en_i && (trig_sel_i == FREE_RUN_SEL);
	// hardware starts only with auto-trigger enabled
	// edges seen while converting are not used and not stored
	assign trig_edge = enable_i && auto_trig_en_i && !free_run && trig_now && !trig_prev_q;
	assign hw_start = trig_edge && (state_q == ST_IDLE);
	// completion on the last converter clock of the conversion
	assign done = (state_q == ST_CONV) && tick && (cnt_q == len_q);

	// comparator crossing into the clock domain
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cmp_meta_q <= 1'b0;
			cmp_q <= 1'b0;
		end else begin
			cmp_meta_q <= comparator_i;
			cmp_q <= cmp_meta_q;
		end
	end

	// edge history tracks always, so a level held at completion is no edge
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_now;
		end
	end

	// prescaler held in reset while disabled
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ps_q <= PS_ZERO;
		end else if (!enable_i || hw_start) begin
			ps_q <= PS_ZERO;
		end else if (ps_q == PS_LAST) begin
			ps_q <= PS_ZERO;
		end else begin
			ps_q <= ps_q + 1'b1;
		end
	end
	// one converter clock period ends each time the prescaler wraps
	assign tick = enable_i && (ps_q == PS_LAST);

	// software start request waits for the next converter clock
	// begins on the next prescaled edge
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pending_q <= 1'b0;
		end else if (!enable_i) begin
			pending_q <= 1'b0;
		end else if (hw_start) begin
			// a hardware start takes over, so no software request is left queued
			pending_q <= 1'b0;
		end else if (start_wr_i && state_q == ST_IDLE) begin
			pending_q <= 1'b1;
		end else if (tick && state_q == ST_IDLE) begin
			pending_q <= 1'b0;
		end
	end

	// first conversion after enabling takes the long form
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			first_q <= 1'b1;
		end else if (!enable_i) begin
			first_q <= 1'b1;
		end else if (state_q == ST_CONV) begin
			first_q <= 1'b0;
		end
	end

	// conversion sequencer
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			len_q <= NORMAL_CYCLES;
		end else if (!enable_i) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if ((pending_q && tick) || hw_start) begin
						state_q <= ST_CONV;
						cnt_q <= (pending_q && tick) ? ONE_TICK : '0;
						len_q <= first_q ? FIRST_CYCLES : NORMAL_CYCLES;
					end
				end
				ST_CONV: begin
					if (done) begin
						// own flag as source restarts at once, flag state ignored
						if (free_run) begin
							cnt_q <= '0;
							len_q <= NORMAL_CYCLES;
						end else begin
							state_q <= ST_IDLE;
							cnt_q <= '0;
						end
					end else if (tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// binary search: sample, then one decision per converter clock, msb first
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			trial_q <= CODE_ZERO;
			bit_q <= CODE_ZERO;
			sample_q <= 1'b0;
		end else if (!enable_i || state_q != ST_CONV) begin
			// a disable drops sample and trial code in the same cycle as the start bit
			trial_q <= CODE_ZERO;
			bit_q <= CODE_ZERO;
			sample_q <= 1'b0;
		end else if (tick) begin
			if (cnt_q == len_q - SAMPLE_BACK) begin
				sample_q <= 1'b1;
				trial_q <= MSB_TRIAL;
				bit_q <= MSB_TRIAL;
			end else if (bit_q != CODE_ZERO) begin
				sample_q <= 1'b0;
				// comparator high means input below trial: drop the bit
				trial_q <= (cmp_q ? (trial_q & ~bit_q) : trial_q) | (bit_q >> 1);
				bit_q <= bit_q >> 1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lock_q <= 1'b0;
		end else if (high_rd_i) begin
			lock_q <= 1'b0;
		end else if (low_rd_i) begin
			lock_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			data_q <= CODE_ZERO;
		end else if (done && !lock_q) begin
			data_q <= trial_q;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			result_q <= '0;
		end else if (!lock_q) begin
			if (left_align_i) begin
				result_q <= {data_q, 6'h00};
			end else begin
				result_q <= {6'h00, data_q};
			end
		end
	end

	// flag rises even when the result was dropped
	// own completion source, a new completion beats a clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_q <= 1'b0;
		end else if (done) begin
			flag_q <= 1'b1;
		end else if (flag_clr_i) begin
			flag_q <= 1'b0;
		end
	end

	// interrupt request and enable mirror
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_q <= 1'b0;
			en_q <= 1'b0;
		end else begin
			irq_q <= (flag_q || done) && int_en_i;
			en_q <= enable_i;
		end
	end

	// locked during a conversion, reopens on the last converter clock
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			route_q <= '{ref_sel: '0, chan_sel: '0, gain_bypass: 1'b1};
		end else if (enable_i && (state_q == ST_IDLE || cnt_q == len_q)) begin
			route_q.ref_sel <= ref_sel_i;
			route_q.chan_sel <= chan_sel_i;
			// gain stage only for differential pairs
			route_q.gain_bypass <= is_single(chan_sel_i);
		end
	end

	// start bit reads one for every conversion
	// cleared with completion in single mode
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			start_bit_o <= 1'b0;
		end else if (!enable_i) begin
			start_bit_o <= 1'b0;
		end else if (done) begin
			start_bit_o <= free_run;
		end else begin
			start_bit_o <= start_bit_o || start_wr_i || pending_q || hw_start ||
				(state_q == ST_CONV);
		end
	end

	assign flag_o = flag_q;
	assign irq_o = irq_q;
	assign result_o = result_q;
	assign route_o = route_q;
	assign analog_en_o = en_q;
	assign sample_o = sample_q;
	assign trial_code_o = trial_q;
endmodule // sac_ctrl

//--- design/sac_pkg.sv
// constants and carrier types for the converter control block
// assumes a single processor clock and plain control ports, no bus
package sac_pkg;
	localparam int unsigned RES_W = 10;
	localparam int unsigned CHAN_W = 5;
	localparam int unsigned REF_W = 2;
	localparam int unsigned TSEL_W = 3;
	localparam int unsigned NUM_SRC = 8;
	localparam int unsigned CNT_W = 5;
	// conversion lengths in converter clock cycles
	localparam logic [CNT_W-1:0] NORMAL_CYCLES = 5'h0D;
	localparam logic [CNT_W-1:0] FIRST_CYCLES = 5'h19;
	// sample point sits this many ticks before the end, the decisions follow one per tick
	localparam logic [CNT_W-1:0] SAMPLE_BACK = 5'h0B;
	localparam logic [CNT_W-1:0] ONE_TICK = 5'h01;
	// channel codes below this are plain pins, single ended
	localparam logic [CHAN_W-1:0] DIFF_FIRST = 5'h08;
	// codes from here on are bandgap and ground, single ended again
	localparam logic [CHAN_W-1:0] DIFF_END = 5'h1E;
	localparam logic [RES_W-1:0] MSB_TRIAL = 10'h200;
	localparam logic [RES_W-1:0] CODE_ZERO = 10'h000;

	// selection applied to the analog side
	typedef struct packed {
		logic [REF_W-1:0] ref_sel;
		logic [CHAN_W-1:0] chan_sel;
		logic gain_bypass;
	} sac_route_t;

	// the two result bytes as software sees them
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} sac_result_t;
endpackage

//--- verification/sac_ctrl_properties.sv
// port checks for the converter control block
// assumes one clock and an asynchronous active high reset
`timescale 1ns/10ps
module sac_ctrl_properties
	import sac_pkg::*;
#(
	parameter int unsigned PRESCALE = 4,
	parameter logic [sac_pkg::TSEL_W-1:0] FREE_RUN_SEL = 3'h0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic start_wr_i,
	input wire logic auto_trig_en_i,
	input wire logic [sac_pkg::TSEL_W-1:0] trig_sel_i,
	input wire logic [sac_pkg::NUM_SRC-1:0] trig_src_i,
	input wire logic left_align_i,
	input wire logic [sac_pkg::REF_W-1:0] ref_sel_i,
	input wire logic [sac_pkg::CHAN_W-1:0] chan_sel_i,
	input wire logic low_rd_i,
	input wire logic high_rd_i,
	input wire logic flag_clr_i,
	input wire logic int_en_i,
	input wire logic comparator_i,
	input wire logic start_bit_o,
	input wire logic flag_o,
	input wire logic irq_o,
	input wire sac_pkg::sac_result_t result_o,
	input wire sac_pkg::sac_route_t route_o,
	input wire logic analog_en_o,
	input wire logic sample_o,
	input wire logic [sac_pkg::RES_W-1:0] trial_code_o
);
	logic lock_q;
	logic src_w;
	// lock set by a low read, cleared by a high read
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lock_q <= 1'b0;
		end else if (high_rd_i) begin
			lock_q <= 1'b0;
		end else if (low_rd_i) begin
			lock_q <= 1'b1;
		end
	end
	// selected trigger level, free running choice excluded
	assign src_w = trig_src_i[trig_sel_i] && (trig_sel_i != FREE_RUN_SEL);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_start_taken: assert property (enable_i && start_wr_i && !start_bit_o |=> start_bit_o)
		else $error("start bit not set by start write");
	a_trig_starts: assert property (enable_i && auto_trig_en_i && !start_bit_o && src_w
		&& !$past(src_w) |=> start_bit_o)
		else $error("trigger edge did not start");
	a_sample_busy: assert property (sample_o |-> start_bit_o)
		else $error("sample with start bit low");
	a_flag_sticky: assert property (flag_o && !flag_clr_i |=> flag_o)
		else $error("flag dropped without clear");
	a_single_clear: assert property ($rose(flag_o) && !auto_trig_en_i |-> !start_bit_o)
		else $error("start bit not cleared with flag");
	a_irq_raise: assert property (flag_o && int_en_i |=> irq_o)
		else $error("irq missing");
	a_irq_masked: assert property (!int_en_i |=> !irq_o)
		else $error("irq while masked");
	a_result_lock: assert property (lock_q && $past(lock_q) && !high_rd_i |=> $stable(result_o))
		else $error("result changed while locked");
	a_route_hold: assert property (!enable_i |=> $stable(route_o))
		else $error("route changed while disabled");
	a_off_idle: assert property (!enable_i [*2] |-> !start_bit_o && !sample_o)
		else $error("activity while disabled");
endmodule // sac_ctrl_properties
bind sac_ctrl sac_ctrl_properties #(.PRESCALE(PRESCALE), .FREE_RUN_SEL(FREE_RUN_SEL)) chk (.*);

//--- verification/sac_ctrl_tb.sv
// self-checking bench for the converter control block
// assumes the analog model answers trial codes; clock 20 ns
`timescale 1ns/10ps
module sac_ctrl_tb;
	import sac_pkg::*;
	typedef struct packed {
		logic al; logic [9:0] lv; logic [1:0] rf; logic [4:0] ch; logic [15:0] res; logic [7:0] rt;
	} sac_row_t;
	logic clk_i = 1'b0, reset_i = 1'b1, enable_i = 1'b0, auto_trig_en_i = 1'b0, int_en_i = 1'b1;
	logic left_align_i = 1'b0, comparator_i, start_bit_o, flag_o, irq_o, analog_en_o, sample_o;
	logic [3:0] strb = 4'h0;
	wire start_wr_i = strb[0];
	wire low_rd_i = strb[1];
	wire high_rd_i = strb[2];
	wire flag_clr_i = strb[3];
	logic [2:0] trig_sel_i = 3'h1;
	logic [7:0] trig_src_i = 8'h00;
	logic [1:0] ref_sel_i = 2'h0;
	logic [4:0] chan_sel_i = 5'h00;
	logic [9:0] trial_code_o, level = 10'h000;
	sac_result_t result_o;
	sac_route_t route_o;
	int miscompares = 0, tests_run = 0;
	// rows: align, level, reference, channel, expected result, expected route
	sac_row_t rows [4] = '{{1'b0, 10'h000, 2'h0, 5'h07, 16'h0000, 8'h0F},
		{1'b0, 10'h3FF, 2'h1, 5'h08, 16'h03FF, 8'h50}, {1'b1, 10'h155, 2'h2, 5'h1D, 16'h5540, 8'hBA},
		{1'b1, 10'h2AA, 2'h3, 5'h1E, 16'hAA80, 8'hFD}};
	always #10 clk_i = ~clk_i;
	sac_ctrl #(.PRESCALE(4), .FREE_RUN_SEL(3'h0)) uut (.*);
	sac_sar_model front (.clk_i(clk_i), .sample_i(sample_o), .level_i(level),
		.trial_i(trial_code_o), .below_o(comparator_i));
	// compare and count
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one-cycle strobe: 0 start, 1 low read, 2 high read, 3 flag clear
	task automatic pulse(input int k);
		@(posedge clk_i);
		strb[k] <= 1'b1;
		@(posedge clk_i);
		strb <= 4'h0;
	endtask
	task automatic wait_flag();
		int n;
		n = 0;
		@(negedge clk_i);
		while (flag_o !== 1'b1) begin
			n++;
			if (n > 300) begin
				miscompares++;
				$display("unexpected timeout waiting for flag");
				final_report();
			end
			@(negedge clk_i);
		end
		@(negedge clk_i);
	endtask
	task automatic conv(input logic [9:0] lv);
		level <= lv;
		pulse(0);
		wait_flag();
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk("reset outputs", {3'h0, start_bit_o, flag_o, irq_o, route_o, analog_en_o, sample_o},
			16'h0004);
		chk("reset result", result_o, 16'h0000);
		chk("reset trial code", {6'h00, trial_code_o}, 16'h0000);
		@(posedge clk_i);
		reset_i <= 1'b0;
		$display("reset test done");
	endtask
	initial begin
		do_reset();
		enable_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			{left_align_i, ref_sel_i, chan_sel_i} <= {rows[i].al, rows[i].rf, rows[i].ch};
			conv(rows[i].lv);
			chk("result", result_o, rows[i].res);
			chk("route", {8'h00, route_o}, {8'h00, rows[i].rt});
			chk("start bit", {14'h0000, start_bit_o, irq_o}, 16'h0001);
			pulse(3);
			$display("row %0d done", i);
		end
		pulse(1);
		level <= 10'h0F0;
		pulse(0);
		repeat (20) @(posedge clk_i);
		chan_sel_i <= 5'h10;
		repeat (2) @(negedge clk_i);
		chk("route mid conversion", {8'h00, route_o}, 16'h00FD);
		wait_flag();
		chk("locked result", result_o, 16'hAA80);
		chk("flag locked", {15'h0000, flag_o}, 16'h0001);
		pulse(3);
		pulse(2);
		conv(10'h0F0);
		chk("unlocked result", result_o, 16'h3C00);
		chk("route after", {8'h00, route_o}, 16'h00E0);
		pulse(3);
		$display("lock test done");
		{left_align_i, auto_trig_en_i, int_en_i, trig_src_i} <= {3'h2, 8'h02};
		wait_flag();
		chk("trigger result", result_o, 16'h00F0);
		pulse(3);
		trig_src_i <= 8'h0A;
		repeat (120) @(negedge clk_i);
		chk("held or unselected", {14'h0000, start_bit_o, irq_o}, 16'h0000);
		@(posedge clk_i);
		trig_src_i <= 8'h00;
		@(posedge clk_i);
		trig_src_i <= 8'h02;
		repeat (20) @(posedge clk_i);
		trig_src_i <= 8'h00;
		@(posedge clk_i);
		trig_src_i <= 8'h02;
		wait_flag();
		pulse(3);
		repeat (80) @(negedge clk_i);
		chk("edge while busy", {14'h0000, start_bit_o, flag_o}, 16'h0000);
		$display("trigger test done");
		{trig_src_i, trig_sel_i} <= 11'h000;
		pulse(0);
		wait_flag();
		pulse(3);
		wait_flag();
		chk("free running", {15'h0000, start_bit_o}, 16'h0001);
		chk("free run code", {6'h00, trial_code_o}, 16'h00F0);
		chk("free run result", result_o, 16'h00F0);
		@(posedge clk_i);
		{enable_i, chan_sel_i} <= 6'h05;
		repeat (3) @(negedge clk_i);
		chk("disabled", {6'h00, start_bit_o, analog_en_o, route_o}, 16'h00E0);
		@(posedge clk_i);
		enable_i <= 1'b1;
		repeat (3) @(negedge clk_i);
		chk("enabled route", {8'h00, route_o}, 16'h00CB);
		$display("free run test done");
		do_reset();
		final_report();
	end
endmodule // sac_ctrl_tb

//--- verification/sac_sar_model.sv
// analog front end model: sample and hold plus comparator
// assumes sample pulse and trial code come from the control block on clk_i
`timescale 1ns/10ps
module sac_sar_model (
	input wire logic clk_i,
	input wire logic sample_i,
	input wire logic [9:0] level_i,
	input wire logic [9:0] trial_i,
	output logic below_o
);
	logic [9:0] held_q = 10'h000;
	// capture the input level at the sample pulse
	always_ff @(posedge clk_i) begin
		if (sample_i) begin
			held_q <= level_i;
		end
	end
	// code zero is ground
	// high while the held level lies below the trial code
	assign below_o = held_q < trial_i;
endmodule // sac_sar_model
